// *** sepr_core.sv ***
// Command, protection and write cycle logic of an SPI serial EEPROM slave.
`timescale 1ns/1ps
`include "sepr_defs.svh"
module sepr_core #(
	parameter int unsigned TWC_CYCLES = `SEPR_TWC_CYCLES,
	parameter bit          BIG_ARRAY  = 1'b0
) (
	input  wire logic                  CLK,
	input  wire logic                  CE,
	input  wire logic                  RST,
	input  wire logic                  LINK_SCK,
	input  wire logic                  CS_N,
	input  wire logic                  SI,
	output logic                       SO,
	output logic                       SO_OE,
	input  wire logic                  WP_N,
	output logic [15:0]                ARR_RADDR,
	input  wire logic [7:0]            ARR_RDATA,
	output sepr_pkg::sepr_arr_wr_t     ARR_WR,
	output logic                       BUSY
);

	localparam int CW = $clog2(TWC_CYCLES + 1);

	// =================================================================
	// Parameter checks
	generate
		if (TWC_CYCLES < 1) begin : g_bad_twc
			$error("TWC_CYCLES must be at least one");
		end
	endgenerate

	// =================================================================
	// Shared functions
	function automatic logic is_prot(input logic [15:0] a, input logic [1:0] bp,
		input logic big);
		logic [15:0] am;
		logic [15:0] qtr;
		logic [15:0] half;
		am   = big ? a : {1'b0, a[14:0]};
		qtr  = big ? `SEPR_QTR_LARGE : `SEPR_QTR_SMALL;
		half = big ? `SEPR_HALF_LARGE : `SEPR_HALF_SMALL;
		case (bp)
			2'h0: is_prot = 1'b0;
			2'h1: is_prot = (am >= qtr);
			2'h2: is_prot = (am >= half);
			default: is_prot = 1'b1;
		endcase
	endfunction

	function automatic sepr_pkg::sepr_link_st_t op_state(input logic [7:0] b,
		input logic busy);
		if (b[7:4] != `SEPR_OP_HI_ZERO) begin
			op_state = sepr_pkg::LK_SKIP;
		end else if (b[2:0] == `SEPR_OP_RD_STATUS) begin
			op_state = sepr_pkg::LK_STATUS;
		end else if (busy) begin
			op_state = sepr_pkg::LK_SKIP;
		end else begin
			case (b[2:0])
				`SEPR_OP_RD_ARRAY: op_state = sepr_pkg::LK_ADDR;
				`SEPR_OP_WR_ARRAY: op_state = sepr_pkg::LK_ADDR;
				`SEPR_OP_WR_STATUS: op_state = sepr_pkg::LK_NEW_STATUS;
				default: op_state = sepr_pkg::LK_SKIP;
			endcase
		end
	endfunction

	function automatic sepr_pkg::sepr_cmd_t op_cmd(input logic [7:0] b, input logic busy);
		if (b[7:4] != `SEPR_OP_HI_ZERO || busy) begin
			op_cmd = sepr_pkg::CMD_NONE;
		end else begin
			case (b[2:0])
				`SEPR_OP_SET_LATCH: op_cmd = sepr_pkg::CMD_SET_LATCH;
				`SEPR_OP_CLR_LATCH: op_cmd = sepr_pkg::CMD_CLR_LATCH;
				`SEPR_OP_WR_STATUS: op_cmd = sepr_pkg::CMD_WR_STATUS;
				`SEPR_OP_WR_ARRAY: op_cmd = sepr_pkg::CMD_WR_ARRAY;
				default: op_cmd = sepr_pkg::CMD_NONE;
			endcase
		end
	endfunction

	function automatic logic [15:0] inc_addr(input logic [15:0] a, input logic big);
		if (big) begin
			inc_addr = 16'(a + 16'h1);
		end else begin
			inc_addr = {1'b0, 15'(a[14:0] + 15'h1)};
		end
	endfunction

	// =================================================================
	// Declarations
	logic                    frame_rst;
	logic [2:0]              bit_cnt_q;
	logic [6:0]              sh_q;
	logic                    byte_done;
	logic [7:0]              byte_in;
	sepr_pkg::sepr_link_st_t st_q;
	logic                    addr_byte_q;
	logic                    ld_q;
	logic [7:0]              out_q;
	logic                    oe_q;
	logic [15:0]             addr_q;
	sepr_pkg::sepr_frame_t   frame_q;
	logic [7:0]              page_q [`SEPR_PAGE_BYTES];
	logic [`SEPR_PAGE_BYTES-1:0] valid_q;
	logic                    tog_q;
	logic [7:0]              snap_q;
	logic                    cs_s;
	logic                    tog_s;
	logic                    wp_s;
	logic                    cs_d_q;
	logic                    seen_q;
	logic                    ppe_q;
	logic [1:0]              bp_q;
	logic                    wel_q;
	sepr_pkg::sepr_core_st_t co_st_q;
	logic [6:0]              idx_q;
	logic [CW-1:0]           cnt_q;
	logic                    hwprot;
	logic                    go;
	logic                    idle;
	logic                    exec_set;
	logic                    exec_clr;
	logic                    exec_sr;
	logic                    exec_wr;
	logic                    done;
	logic [7:0]              status_image;
	logic [15:0]             prog_addr;

	// =================================================================
	// Link domain: frame sequencing
	// Chip select high holds the frame logic in reset, so every frame
	// starts cleanly from its falling edge.
	assign frame_rst = RST | CS_N;
	assign byte_done = (bit_cnt_q == 3'h7);
	assign byte_in   = {sh_q, SI};

	always_ff @(posedge LINK_SCK or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_q   <= 3'h0;
			sh_q        <= 7'h00;
			st_q        <= sepr_pkg::LK_OPCODE;
			addr_byte_q <= 1'b0;
			ld_q        <= 1'b0;
		end else begin
			bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
			sh_q      <= byte_in[6:0];
			ld_q      <= 1'b0;
			if (byte_done) begin
				case (st_q)
					sepr_pkg::LK_OPCODE: begin
						st_q <= op_state(byte_in, snap_q[`SEPR_SR_BUSY]);
						ld_q <= (op_state(byte_in, snap_q[`SEPR_SR_BUSY]) == sepr_pkg::LK_STATUS);
					end
					sepr_pkg::LK_ADDR: begin
						addr_byte_q <= 1'b1;
						if (addr_byte_q) begin
							if (frame_q.cmd == sepr_pkg::CMD_WR_ARRAY) begin
								st_q <= sepr_pkg::LK_PROGRAM;
							end else begin
								st_q <= sepr_pkg::LK_STREAM;
								ld_q <= 1'b1;
							end
						end
					end
					sepr_pkg::LK_STREAM: begin
						ld_q <= 1'b1;
					end
					sepr_pkg::LK_STATUS: begin
						ld_q <= 1'b1;
					end
					sepr_pkg::LK_NEW_STATUS: begin
						st_q <= sepr_pkg::LK_SKIP;
					end
					default: begin
						st_q <= st_q;
					end
				endcase
			end
		end
	end

	// =================================================================
	// Link domain: results that outlive the frame
	// These hold still once the clock stops with chip select high, which
	// is what lets the core domain read them after the rising edge.
	always_ff @(posedge LINK_SCK or posedge RST) begin
		if (RST) begin
			addr_q  <= 16'h0000;
			frame_q <= '{cmd: sepr_pkg::CMD_NONE, new_status: 8'h00, aligned: 1'b0};
			valid_q <= '0;
			tog_q   <= 1'b0;
		end else if (!CS_N) begin
			frame_q.aligned <= byte_done;
			if (byte_done) begin
				case (st_q)
					sepr_pkg::LK_OPCODE: begin
						frame_q.cmd <= op_cmd(byte_in, snap_q[`SEPR_SR_BUSY]);
						tog_q       <= ~tog_q;
						if (op_cmd(byte_in, snap_q[`SEPR_SR_BUSY]) == sepr_pkg::CMD_WR_ARRAY) begin
							valid_q <= '0;
						end
					end
					sepr_pkg::LK_ADDR: begin
						if (!addr_byte_q) begin
							addr_q[15:8] <= {byte_in[7] & BIG_ARRAY, byte_in[6:0]};
						end else begin
							addr_q[7:0] <= byte_in;
						end
					end
					sepr_pkg::LK_STREAM: begin
						addr_q <= inc_addr(addr_q, BIG_ARRAY);
					end
					sepr_pkg::LK_PROGRAM: begin
						valid_q[addr_q[6:0]] <= 1'b1;
						addr_q[6:0]          <= 7'(addr_q[6:0] + 7'h01);
					end
					sepr_pkg::LK_NEW_STATUS: begin
						frame_q.new_status <= byte_in;
					end
					default: begin
						addr_q <= addr_q;
					end
				endcase
			end
		end
	end

	// Page buffer has no reset; only bytes marked valid are ever used.
	always_ff @(posedge LINK_SCK) begin
		if (!CS_N && byte_done && st_q == sepr_pkg::LK_PROGRAM) begin
			page_q[addr_q[6:0]] <= byte_in;
		end
	end

	assign ARR_RADDR = addr_q;

	// =================================================================
	// Link domain: serial output on the falling clock edge
	always_ff @(negedge LINK_SCK or posedge frame_rst) begin
		if (frame_rst) begin
			out_q <= 8'h00;
			oe_q  <= 1'b0;
		end else if (ld_q) begin
			out_q <= (st_q == sepr_pkg::LK_STATUS) ? snap_q : ARR_RDATA;
			oe_q  <= 1'b1;
		end else begin
			out_q <= {out_q[6:0], 1'b0};
		end
	end

	assign SO    = out_q[7];
	assign SO_OE = oe_q;

	// =================================================================
	// Crossings into the core domain
	sepr_sync #(.W(3)) u_sync (
		.CLK (CLK),
		.CE  (CE),
		.RST (RST),
		.D   ({~CS_N, tog_q, ~WP_N}),
		.Q   ({cs_s, tog_s, wp_s})
	);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cs_d_q <= 1'b0;
			seen_q <= 1'b0;
		end else if (CE) begin
			cs_d_q <= cs_s;
			if (!cs_s && cs_d_q) begin
				seen_q <= tog_s;
			end
		end
	end

	// A frame is acted on only at chip select rise, only if it carried a
	// fresh opcode and ended on a byte boundary.
	assign go = !cs_s && cs_d_q && (tog_s != seen_q) && frame_q.aligned;

	// =================================================================
	// Core domain: protection and command execution
	assign hwprot   = ppe_q && wp_s;
	assign idle     = (co_st_q == sepr_pkg::CO_IDLE);
	assign exec_set = go && idle && frame_q.cmd == sepr_pkg::CMD_SET_LATCH;
	assign exec_clr = go && idle && frame_q.cmd == sepr_pkg::CMD_CLR_LATCH;
	assign exec_sr  = go && idle && frame_q.cmd == sepr_pkg::CMD_WR_STATUS && wel_q && !hwprot;
	assign exec_wr  = go && idle && frame_q.cmd == sepr_pkg::CMD_WR_ARRAY && wel_q && |valid_q;
	assign done     = (co_st_q == sepr_pkg::CO_SETTLE) && (cnt_q == CW'(TWC_CYCLES - 1));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ppe_q <= `SEPR_RST_PPE;
			bp_q  <= `SEPR_RST_BP;
		end else if (CE && exec_sr) begin
			ppe_q <= frame_q.new_status[`SEPR_SR_PPE];
			bp_q  <= {frame_q.new_status[`SEPR_SR_BPH], frame_q.new_status[`SEPR_SR_BPL]};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wel_q <= `SEPR_RST_WEL;
		end else if (CE) begin
			if (done) begin
				wel_q <= 1'b0;
			end else if (exec_set) begin
				wel_q <= 1'b1;
			end else if (exec_clr) begin
				wel_q <= 1'b0;
			end
		end
	end

	// =================================================================
	// Core domain: self-timed write cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			co_st_q <= sepr_pkg::CO_IDLE;
			idx_q   <= 7'h00;
			cnt_q   <= '0;
		end else if (CE) begin
			case (co_st_q)
				sepr_pkg::CO_IDLE: begin
					idx_q <= 7'h00;
					cnt_q <= '0;
					if (exec_wr) begin
						co_st_q <= sepr_pkg::CO_PROGRAM;
					end else if (exec_sr) begin
						co_st_q <= sepr_pkg::CO_SETTLE;
					end
				end
				sepr_pkg::CO_PROGRAM: begin
					idx_q <= 7'(idx_q + 7'h01);
					if (idx_q == 7'h7F) begin
						co_st_q <= sepr_pkg::CO_SETTLE;
					end
				end
				sepr_pkg::CO_SETTLE: begin
					cnt_q <= CW'(cnt_q + 1'b1);
					if (done) begin
						co_st_q <= sepr_pkg::CO_IDLE;
					end
				end
				default: begin
					co_st_q <= sepr_pkg::CO_IDLE;
				end
			endcase
		end
	end

	assign BUSY = !idle;

	// The write cycle walks the whole page once; skipped bytes keep the
	// array untouched, so a short page leaves the rest as it was.
	assign prog_addr = {addr_q[15:7], idx_q};

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ARR_WR <= '{we: 1'b0, addr: 16'h0000, data: 8'h00};
		end else if (CE) begin
			ARR_WR.we   <= (co_st_q == sepr_pkg::CO_PROGRAM) && valid_q[idx_q]
				&& !is_prot(prog_addr, bp_q, BIG_ARRAY);
			ARR_WR.addr <= prog_addr;
			ARR_WR.data <= page_q[idx_q];
		end
	end

	// =================================================================
	// Status image, frozen while chip select is low
	// Freezing avoids a torn status byte when busy ends mid-frame.
	assign status_image = !idle ? `SEPR_SR_BUSY_IMAGE
		: {ppe_q, 3'h0, bp_q, wel_q, 1'b0};

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			snap_q <= 8'h00;
		end else if (CE && !cs_s) begin
			snap_q <= status_image;
		end
	end

endmodule

// *** sepr_core_props.sv ***
// Port checks for the serial EEPROM command and protection core.
`timescale 1ns/1ps
module sepr_core_props #(
	parameter int unsigned TWC_CYCLES = 20,
	parameter bit          BIG_ARRAY  = 1'b0
) (
	input wire logic                   CLK,
	input wire logic                   CE,
	input wire logic                   RST,
	input wire logic                   LINK_SCK,
	input wire logic                   CS_N,
	input wire logic                   SO_OE,
	input wire logic [15:0]            ARR_RADDR,
	input wire sepr_pkg::sepr_arr_wr_t ARR_WR,
	input wire logic                   BUSY
);
	logic [31:0] busy_cnt_q;
	logic        seen_q;
	logic [15:0] last_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_cnt_q <= 32'h0;
		end else if (CE) begin
			busy_cnt_q <= BUSY ? busy_cnt_q + 32'h1 : 32'h0;
		end
	end

	// Remembers the last programmed address of the running cycle only.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			seen_q <= 1'b0;
			last_q <= 16'h0;
		end else if (!BUSY) begin
			seen_q <= 1'b0;
		end else if (ARR_WR.we) begin
			seen_q <= 1'b1;
			last_q <= ARR_WR.addr;
		end
	end

	chk_oe_deselect: assert property (@(posedge CLK) disable iff (RST)
		CS_N && $past(CS_N) |-> !SO_OE) else $error("output enabled while deselected");
	chk_we_in_busy: assert property (@(posedge CLK) disable iff (RST)
		ARR_WR.we |-> BUSY && busy_cnt_q <= 32'h82) else $error("program outside its slot");
	chk_page_order: assert property (@(posedge CLK) disable iff (RST)
		ARR_WR.we && seen_q |-> ARR_WR.addr[15:7] == last_q[15:7]
		&& ARR_WR.addr[6:0] > last_q[6:0]) else $error("page order broken");
	chk_small_waddr: assert property (@(posedge CLK) disable iff (RST)
		!BIG_ARRAY && ARR_WR.we |-> !ARR_WR.addr[15]) else $error("top write bit set");
	chk_small_raddr: assert property (@(posedge LINK_SCK) disable iff (RST)
		!BIG_ARRAY |-> !ARR_RADDR[15]) else $error("top read bit set");
	chk_busy_start: assert property (@(posedge CLK) disable iff (RST)
		$rose(BUSY) |-> $past(CS_N) && $past(CS_N, 2)) else $error("busy while selected");
	chk_busy_length: assert property (@(posedge CLK) disable iff (RST)
		$fell(BUSY) |-> busy_cnt_q >= TWC_CYCLES && busy_cnt_q <= TWC_CYCLES + 130)
		else $error("busy length wrong");
	chk_read_step: assert property (@(posedge LINK_SCK) disable iff (RST || CS_N)
		SO_OE && $past(SO_OE) && $changed(ARR_RADDR) |->
		ARR_RADDR == (($past(ARR_RADDR) + 16'h1) & {BIG_ARRAY, 15'h7FFF}))
		else $error("read address step wrong");
endmodule

// *** sepr_defs.svh ***
// Constants for the serial EEPROM command and protection core.
`ifndef SEPR_DEFS_SVH
`define SEPR_DEFS_SVH

// =====================================================================
// Instruction codes: upper nibble zero, bit 3 ignored, low three bits.
`define SEPR_OP_HI_ZERO     4'h0
`define SEPR_OP_SET_LATCH   3'h6
`define SEPR_OP_CLR_LATCH   3'h4
`define SEPR_OP_RD_STATUS   3'h5
`define SEPR_OP_WR_STATUS   3'h1
`define SEPR_OP_RD_ARRAY    3'h3
`define SEPR_OP_WR_ARRAY    3'h2

// =====================================================================
// Status byte field positions and images.
`define SEPR_SR_PPE         7
`define SEPR_SR_BPH         3
`define SEPR_SR_BPL         2
`define SEPR_SR_WEL         1
`define SEPR_SR_BUSY        0
`define SEPR_SR_BUSY_IMAGE  8'hFF

// =====================================================================
// Reset values.
`define SEPR_RST_PPE        1'h0
`define SEPR_RST_BP         2'h0
`define SEPR_RST_WEL        1'h0

// =====================================================================
// Block protect boundaries for both densities.
`define SEPR_QTR_SMALL      16'h6000
`define SEPR_HALF_SMALL     16'h4000
`define SEPR_QTR_LARGE      16'hC000
`define SEPR_HALF_LARGE     16'h8000

// =====================================================================
// Page geometry and write cycle timing.
`define SEPR_PAGE_BITS      7
`define SEPR_PAGE_BYTES     128
`define SEPR_TWC_US         5000
`define SEPR_CLK_MHZ        200
`define SEPR_TWC_CYCLES     (`SEPR_TWC_US * `SEPR_CLK_MHZ)

`endif

// *** sepr_host.sv ***
// Mode 0 SPI master model driving frames into the core.
`timescale 1ns/1ps
module sepr_host (
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	logic [7:0] tx [0:135];
	logic [7:0] rx [0:135];
	logic       saw_oe;

	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b1;
		saw_oe = 1'b0;
	end

	// The clock rests low between frames; it runs only inside a frame.
	task automatic xfer(input int n);
		saw_oe = 1'b0;
		cs_n = 1'b0;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				si = tx[b][i];
				#24 sck = 1'b1;
				rx[b][i] = so;
				saw_oe = saw_oe | so_oe;
				#24 sck = 1'b0;
			end
		end
		#10 cs_n = 1'b1;
		si = ~si;
		#60;
	endtask
endmodule

// *** sepr_pkg.sv ***
// Types shared by the serial EEPROM command and protection core.
package sepr_pkg;

	// =================================================================
	// Commands handed from the link domain to the core domain.
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SET_LATCH,
		CMD_CLR_LATCH,
		CMD_WR_STATUS,
		CMD_WR_ARRAY
	} sepr_cmd_t;

	// =================================================================
	// Link side frame states.
	typedef enum logic [2:0] {
		LK_OPCODE,
		LK_ADDR,
		LK_PROGRAM,
		LK_STREAM,
		LK_STATUS,
		LK_NEW_STATUS,
		LK_SKIP
	} sepr_link_st_t;

	// =================================================================
	// Core side write cycle states.
	typedef enum logic [1:0] {
		CO_IDLE,
		CO_PROGRAM,
		CO_SETTLE
	} sepr_core_st_t;

	// =================================================================
	// Frame result left by the link for the core.
	typedef struct packed {
		sepr_cmd_t  cmd;
		logic [7:0] new_status;
		logic       aligned;
	} sepr_frame_t;

	// =================================================================
	// Array program port.
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  data;
	} sepr_arr_wr_t;

endpackage

// *** sepr_sync.sv ***
// Two flip-flop synchroniser for levels entering the core clock domain.
`timescale 1ns/1ps
module sepr_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         CE,
	input  wire logic         RST,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);

	logic [W-1:0] s1_q;

	// =================================================================
	// The first stage feeds only the second stage.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s1_q <= '0;
			Q    <= '0;
		end else if (CE) begin
			s1_q <= D;
			Q    <= s1_q;
		end
	end

endmodule

// *** testbench.sv ***
// Self-checking bench for the serial EEPROM command and protection core.
`timescale 1ns/1ps
module testbench;
	localparam int unsigned TWC = 1000;
	logic                   clk, rst, ce, wp_n, cs_n, sck, si, so, so_oe, busy;
	logic [15:0]            raddr;
	logic [7:0]             rdata;
	logic [7:0]             mem [0:65535];
	sepr_pkg::sepr_arr_wr_t wr;
	int                     num_errors, comparisons;

	sepr_core #(.TWC_CYCLES(TWC), .BIG_ARRAY(1'b0)) sepr_core_i (
		.CLK(clk), .CE(ce), .RST(rst), .LINK_SCK(sck), .CS_N(cs_n), .SI(si),
		.SO(so), .SO_OE(so_oe), .WP_N(wp_n), .ARR_RADDR(raddr),
		.ARR_RDATA(rdata), .ARR_WR(wr), .BUSY(busy));
	sepr_host sepr_host_i (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

	assign rdata = mem[raddr];
	always @(posedge clk) begin
		if (wr.we) begin
			mem[wr.addr] <= wr.data;
		end
	end

	function automatic logic [7:0] pre(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_idle;
		int k;
		repeat (8) @(negedge clk);
		for (k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
		if (k == 2000) begin
			num_errors++;
			$display("[FAIL] %0t busy never ended", $time);
			conclude();
		end
	endtask

	task automatic frame1(input logic [7:0] op);
		sepr_host_i.tx[0] = op;
		sepr_host_i.xfer(1);
	endtask

	task automatic rd_status(output logic [7:0] v);
		sepr_host_i.tx[0] = 8'h05;
		sepr_host_i.tx[1] = 8'h00;
		sepr_host_i.xfer(2);
		v = sepr_host_i.rx[1];
	endtask

	task automatic wr_status(input logic [7:0] v);
		frame1(8'h06);
		sepr_host_i.tx[0] = 8'h01;
		sepr_host_i.tx[1] = v;
		sepr_host_i.xfer(2);
		wait_idle();
	endtask

	// Data bytes are placed in tx from index 3 by the caller beforehand.
	task automatic wr_array(input logic [15:0] a, input int n, input bit latch);
		if (latch) frame1(8'h06);
		sepr_host_i.tx[0] = 8'h02;
		sepr_host_i.tx[1] = a[15:8];
		sepr_host_i.tx[2] = a[7:0];
		sepr_host_i.xfer(n + 3);
	endtask

	task automatic t_reset;
		logic [7:0] v;
		rd_status(v);
		check8(v, 8'h00, "status after reset");
	endtask

	task automatic t_page;
		logic [7:0] exp [0:127];
		logic [7:0] v;
		for (int i = 0; i < 128; i++) exp[i] = pre(16'h0180 + 16'(i));
		for (int i = 0; i < 130; i++) begin
			sepr_host_i.tx[3 + i] = 8'(i) + 8'h40;
			exp[(i + 127) % 128] = 8'(i) + 8'h40;
		end
		wr_array(16'h01FF, 130, 1'b1);
		rd_status(v);
		check8(v, 8'hFF, "busy status");
		frame1(8'h06);
		sepr_host_i.tx[0] = 8'h03;
		sepr_host_i.xfer(4);
		check8({7'h0, sepr_host_i.saw_oe}, 8'h00, "read while busy");
		wait_idle();
		rd_status(v);
		check8(v, 8'h00, "latch after cycle");
		for (int i = 0; i < 128; i++) check8(mem[16'h0180 + 16'(i)], exp[i], "page");
		check8(mem[16'h0200], pre(16'h0200), "next page");
	endtask

	task automatic t_read;
		sepr_host_i.tx[0] = 8'h03;
		sepr_host_i.tx[1] = 8'hFF;
		sepr_host_i.tx[2] = 8'hFE;
		sepr_host_i.xfer(7);
		for (int i = 0; i < 4; i++) check8(sepr_host_i.rx[3 + i],
			pre((16'h7FFE + 16'(i)) & 16'h7FFF), "stream");
		sepr_host_i.tx[1] = 8'h02;
		sepr_host_i.tx[2] = 8'h00;
		sepr_host_i.xfer(4);
		check8(sepr_host_i.rx[3], pre(16'h0200), "single read");
	endtask

	task automatic t_nolatch;
		logic [7:0] v;
		sepr_host_i.tx[3] = 8'hA5;
		wr_array(16'h0300, 1, 1'b0);
		repeat (20) @(negedge clk);
		check8({7'h0, busy}, 8'h00, "no cycle");
		rd_status(v);
		check8(v, 8'h00, "next frame");
		check8(mem[16'h0300], pre(16'h0300), "discarded");
	endtask

	task automatic t_levels;
		logic [15:0] p [0:3];
		logic [7:0]  cur [0:3];
		logic [7:0]  v;
		p = '{16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000};
		for (int j = 0; j < 4; j++) cur[j] = pre(p[j]);
		for (int l = 0; l < 4; l++) begin
			wr_status(8'(l << 2));
			rd_status(v);
			check8(v, 8'(l << 2), "level status");
			for (int j = 0; j < 4; j++) begin
				sepr_host_i.tx[3] = 8'h10 + 8'(l);
				wr_array(p[j], 1, 1'b1);
				wait_idle();
				if (!(l == 3 || (l == 2 && j > 0) || (l == 1 && j == 3))) cur[j] = 8'h10 + 8'(l);
				check8(mem[p[j]], cur[j], "probe");
			end
		end
	endtask

	task automatic t_hw;
		logic [7:0] v;
		@(negedge clk);
		wp_n = 1'b0;
		wr_status(8'h80);
		rd_status(v);
		check8(v, 8'h80, "enable set");
		wr_status(8'h0C);
		rd_status(v);
		check8(v & 8'hFD, 8'h80, "locked");
		wr_status(8'h00);
		rd_status(v);
		check8(v & 8'hFD, 8'h80, "enable held");
		@(negedge clk);
		wp_n = 1'b1;
		wr_status(8'h00);
		rd_status(v);
		check8(v, 8'h00, "pin released");
	endtask

	// A low clock enable must hold a running write cycle where it stands.
	task automatic t_freeze;
		logic [7:0] v;
		frame1(8'h06);
		sepr_host_i.tx[0] = 8'h01;
		sepr_host_i.tx[1] = 8'h04;
		sepr_host_i.xfer(2);
		@(negedge clk);
		ce = 1'b0;
		repeat (1100) @(negedge clk);
		check8({7'h0, busy}, 8'h01, "frozen cycle");
		ce = 1'b1;
		wait_idle();
		rd_status(v);
		check8(v, 8'h04, "after freeze");
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wp_n = 1'b1;
		num_errors = 0;
		comparisons = 0;
		for (int a = 0; a < 65536; a++) mem[a] = pre(16'(a));
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		t_page();
		t_read();
		t_nolatch();
		t_levels();
		t_hw();
		t_freeze();
		conclude();
	end
endmodule

bind sepr_core sepr_core_props #(.TWC_CYCLES(TWC_CYCLES), .BIG_ARRAY(BIG_ARRAY)) sepr_core_props_i (
	.CLK(CLK), .CE(CE), .RST(RST), .LINK_SCK(LINK_SCK), .CS_N(CS_N), .SO_OE(SO_OE),
	.ARR_RADDR(ARR_RADDR), .ARR_WR(ARR_WR), .BUSY(BUSY));
